// [hw/ewp_pkg.sv]
package ewp_pkg;

  // ==========================================================================
  // instruction bytes
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] CMD_SET_LATCH = 8'h06;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;

  // ==========================================================================
  // status byte layout
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_LATCH_POS = 1;
  localparam int STAT_BP_LO_POS = 2;
  localparam int STAT_BP_HI_POS = 3;
  localparam int STAT_PROT_EN_POS = 7;
  localparam logic STAT_PROT_EN_RESET = 1'b0;
  localparam logic [1:0] STAT_BP_RESET = 2'h0;
  localparam logic STAT_LATCH_RESET = 1'b0;

  typedef struct packed {
    logic pinProtectEnable;
    logic [2:0] spare;
    logic blockProtectHi;
    logic blockProtectLo;
    logic writeLatchFlag;
    logic writeBusy;
  } ewp_status_t;

  // ==========================================================================
  // array geometry and protection bases
  localparam int ADDR_W = 15;
  localparam int PAGE_AW = 6;
  localparam logic [6:0] PAGE_BYTES = 7'h40;
  localparam logic [14:0] PROT_QUARTER_BASE = 15'h6000;
  localparam logic [14:0] PROT_HALF_BASE = 15'h4000;

  // ==========================================================================
  // frame bit counts
  localparam logic [11:0] CMD_BITS = 12'h008;
  localparam logic [11:0] STATUS_WR_BITS = 12'h010;
  localparam logic [11:0] ARRAY_HDR_BITS = 12'h018;
  localparam logic [11:0] ARRAY_MIN_WR_BITS = 12'h020;
  localparam logic [11:0] BIT_CNT_MAX = 12'hFFF;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_CYCLE_NS = 4000;
  localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // pins and array port
  localparam int PIN_CS = 3;
  localparam int PIN_SCK = 2;
  localparam int PIN_SI = 1;
  localparam int PIN_WP = 0;
  localparam logic [3:0] PIN_SYNC_RESET = 4'h9;

  typedef struct packed {
    logic chipSelN;
    logic serialClk;
    logic serialIn;
    logic writeProtectN;
  } ewp_pins_t;

  typedef struct packed {
    logic valid;
    logic [14:0] addr;
    logic [7:0] data;
  } ewp_mem_wr_t;

endpackage : ewp_pkg

// [hw/ewp_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none

module ewp_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial pins
  input wire ewp_pkg::ewp_pins_t pins,
  output logic serialOut,
  output logic serialOutOeN,
  // array port
  output logic [ewp_pkg::ADDR_W-1:0] memRdAddr,
  input wire logic [7:0] memRdData,
  output ewp_pkg::ewp_mem_wr_t memWr,
  // status view
  output ewp_pkg::ewp_status_t statusView,
  output logic standby,
  output logic writeRejected
);
  import ewp_pkg::*;

  typedef enum logic [0:0] {WC_IDLE, WC_PROGRAM} ewp_wc_t;

  function automatic logic isProtected(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
    logic p;
    p = 1'b0;
    case (bp)
      2'b00: p = 1'b0;
      2'b01: p = (a >= PROT_QUARTER_BASE);
      2'b10: p = (a >= PROT_HALF_BASE);
      default: p = 1'b1;
    endcase
    return p;
  endfunction : isProtected

  // ==========================================================================
  // pin synchronisers
  logic [3:0] pinVec, cleanVec, prev_reg;

  assign pinVec = pins;

  for (genvar i = 0; i < 4; i++) begin : g_sync
    logic s1, s2, s3, c;
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1 <= PIN_SYNC_RESET[i];
        s2 <= PIN_SYNC_RESET[i];
        s3 <= PIN_SYNC_RESET[i];
        c <= PIN_SYNC_RESET[i];
      end else begin
        s1 <= pinVec[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          c <= s3;
        end
      end
    end
    assign cleanVec[i] = c;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_reg <= PIN_SYNC_RESET;
    end else begin
      prev_reg <= cleanVec;
    end
  end

  logic csFall, csRise, sckRise, sckFall, armed_reg, active;

  assign csFall = prev_reg[PIN_CS] && !cleanVec[PIN_CS];
  assign csRise = !prev_reg[PIN_CS] && cleanVec[PIN_CS];
  assign sckRise = !prev_reg[PIN_SCK] && cleanVec[PIN_SCK];
  assign sckFall = prev_reg[PIN_SCK] && !cleanVec[PIN_SCK];
  assign active = armed_reg && !cleanVec[PIN_CS];

  // ==========================================================================
  // select tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
    end else if (csFall) begin
      armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      standby <= 1'b1;
    end else begin
      standby <= !active;
    end
  end

  // ==========================================================================
  // frame shifter
  logic [11:0] bitCnt_reg, bitCnt_next;
  logic [15:0] sh_reg, sh_next;
  logic [7:0] cmd_reg, statusData_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic frameBusy_reg, busy;
  ewp_wc_t wc_reg;

  assign busy = (wc_reg == WC_PROGRAM);
  assign bitCnt_next = (bitCnt_reg == BIT_CNT_MAX) ? bitCnt_reg : bitCnt_reg + 12'h001;
  assign sh_next = {sh_reg[14:0], cleanVec[PIN_SI]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bitCnt_reg <= '0;
      sh_reg <= '0;
      cmd_reg <= '0;
      addr_reg <= '0;
      statusData_reg <= '0;
      frameBusy_reg <= 1'b0;
    end else if (csFall) begin
      bitCnt_reg <= '0;
      frameBusy_reg <= busy;
    end else if (active && sckRise) begin
      bitCnt_reg <= bitCnt_next;
      sh_reg <= sh_next;
      if (bitCnt_next == CMD_BITS) begin
        cmd_reg <= sh_next[7:0];
      end
      if (bitCnt_next == STATUS_WR_BITS) begin
        statusData_reg <= sh_next[7:0];
      end
      if (bitCnt_next == ARRAY_HDR_BITS) begin
        addr_reg <= sh_next[ADDR_W-1:0];
      end
    end
  end

  // ==========================================================================
  // page buffer fill
  logic [7:0] pageBuf [0:(1 << PAGE_AW) - 1];
  logic [PAGE_AW-1:0] fillPtr_reg;
  logic [6:0] fillCnt_reg;
  logic dataByteDone;

  assign dataByteDone = active && sckRise && !frameBusy_reg && (cmd_reg == CMD_WRITE)
    && (bitCnt_next > ARRAY_HDR_BITS) && (bitCnt_next[2:0] == 3'h0)
    && (bitCnt_next != BIT_CNT_MAX);

  always_ff @(posedge clk) begin
    if (dataByteDone) begin
      pageBuf[addr_reg[PAGE_AW-1:0] + fillPtr_reg] <= sh_next[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fillPtr_reg <= '0;
      fillCnt_reg <= '0;
    end else if (csFall) begin
      fillPtr_reg <= '0;
      fillCnt_reg <= '0;
    end else if (dataByteDone) begin
      fillPtr_reg <= fillPtr_reg + 1'b1;
      if (fillCnt_reg != PAGE_BYTES) begin
        fillCnt_reg <= fillCnt_reg + 7'h01;
      end
    end
  end

  // ==========================================================================
  // commit decode at select release
  logic latch_reg, protEn_reg, commitSet, commitClear, wrStatusReq, wrArrayReq;
  logic [1:0] bp_reg;
  logic wrStatusOk, wrArrayOk, commitOk, cycleDone;

  always_comb begin
    commitSet = armed_reg && csRise && !frameBusy_reg
      && (cmd_reg == CMD_SET_LATCH) && (bitCnt_reg == CMD_BITS);
    commitClear = armed_reg && csRise && !frameBusy_reg
      && (cmd_reg == CMD_CLEAR_LATCH) && (bitCnt_reg == CMD_BITS);
    wrStatusReq = armed_reg && csRise && !frameBusy_reg
      && (cmd_reg == CMD_WRITE_STATUS) && (bitCnt_reg == STATUS_WR_BITS);
    wrArrayReq = armed_reg && csRise && !frameBusy_reg && (cmd_reg == CMD_WRITE)
      && (bitCnt_reg >= ARRAY_MIN_WR_BITS) && (bitCnt_reg[2:0] == 3'h0)
      && (bitCnt_reg != BIT_CNT_MAX);
    wrStatusOk = latch_reg && (!protEn_reg || cleanVec[PIN_WP]);
    wrArrayOk = latch_reg && !isProtected(addr_reg, bp_reg);
    commitOk = (wrStatusReq && wrStatusOk) || (wrArrayReq && wrArrayOk);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      writeRejected <= 1'b0;
    end else begin
      writeRejected <= (wrStatusReq && !wrStatusOk) || (wrArrayReq && !wrArrayOk);
    end
  end

  // ==========================================================================
  // write latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_reg <= STAT_LATCH_RESET;
    end else if (commitSet) begin
      latch_reg <= 1'b1;
    end else if (commitClear || cycleDone) begin
      latch_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // status protection bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      protEn_reg <= STAT_PROT_EN_RESET;
      bp_reg <= STAT_BP_RESET;
    end else if (wrStatusReq && wrStatusOk) begin
      protEn_reg <= statusData_reg[STAT_PROT_EN_POS];
      bp_reg <= {statusData_reg[STAT_BP_HI_POS], statusData_reg[STAT_BP_LO_POS]};
    end
  end

  always_comb begin
    statusView = '0;
    statusView.pinProtectEnable = protEn_reg;
    statusView.blockProtectHi = bp_reg[1];
    statusView.blockProtectLo = bp_reg[0];
    statusView.writeLatchFlag = latch_reg;
    statusView.writeBusy = busy;
  end

  // ==========================================================================
  // internal write cycle
  logic [15:0] cycCnt_reg;
  logic [6:0] drainCnt_reg, drainLen_reg;
  logic [PAGE_AW-1:0] drainIdx;

  assign cycleDone = busy && (cycCnt_reg == 16'(WRITE_CYCLE_CYC - 1));
  assign drainIdx = addr_reg[PAGE_AW-1:0] + drainCnt_reg[PAGE_AW-1:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wc_reg <= WC_IDLE;
      cycCnt_reg <= '0;
      drainCnt_reg <= '0;
      drainLen_reg <= '0;
    end else begin
      case (wc_reg)
        WC_IDLE: begin
          cycCnt_reg <= '0;
          drainCnt_reg <= '0;
          if (commitOk) begin
            wc_reg <= WC_PROGRAM;
            drainLen_reg <= wrArrayReq ? fillCnt_reg : 7'h00;
          end
        end
        WC_PROGRAM: begin
          cycCnt_reg <= cycCnt_reg + 16'h0001;
          if (drainCnt_reg != drainLen_reg) begin
            drainCnt_reg <= drainCnt_reg + 7'h01;
          end
          if (cycleDone) begin
            wc_reg <= WC_IDLE;
          end
        end
        default: begin
          wc_reg <= WC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memWr <= '0;
    end else begin
      memWr.valid <= busy && (drainCnt_reg != drainLen_reg);
      memWr.addr <= {addr_reg[ADDR_W-1:PAGE_AW], drainIdx};
      memWr.data <= pageBuf[drainIdx];
    end
  end

  // ==========================================================================
  // serial output
  logic [7:0] outSh_reg, loadVal;
  logic rdArray, rdStatus, loadByte;

  always_comb begin
    rdStatus = (cmd_reg == CMD_READ_STATUS) && (bitCnt_reg >= CMD_BITS);
    rdArray = !frameBusy_reg && (cmd_reg == CMD_READ) && (bitCnt_reg >= ARRAY_HDR_BITS);
    loadByte = active && sckFall && (rdStatus || rdArray) && (bitCnt_reg[2:0] == 3'h0);
    loadVal = rdStatus ? statusView : memRdData;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memRdAddr <= '0;
    end else if (active && sckRise && (bitCnt_next == ARRAY_HDR_BITS)) begin
      memRdAddr <= sh_next[ADDR_W-1:0];
    end else if (loadByte && rdArray) begin
      memRdAddr <= memRdAddr + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serialOut <= 1'b0;
      serialOutOeN <= 1'b1;
      outSh_reg <= '0;
    end else if (!active) begin
      serialOutOeN <= 1'b1;
    end else if (loadByte) begin
      serialOut <= loadVal[7];
      outSh_reg <= {loadVal[6:0], 1'b0};
      serialOutOeN <= 1'b0;
    end else if (sckFall && !serialOutOeN) begin
      serialOut <= outSh_reg[7];
      outSh_reg <= {outSh_reg[6:0], 1'b0};
    end
  end

endmodule : ewp_ctrl
`default_nettype wire

// [sim/ewp_ctrl_props.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========
// checker on the top ports
module ewp_ctrl_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial side
  input wire ewp_pkg::ewp_pins_t pins,
  input wire logic serialOut,
  input wire logic serialOutOeN,
  // array side
  input wire logic [ewp_pkg::ADDR_W-1:0] memRdAddr,
  input wire logic [7:0] memRdData,
  input wire ewp_pkg::ewp_mem_wr_t memWr,
  // status
  input wire ewp_pkg::ewp_status_t statusView,
  input wire logic standby,
  input wire logic writeRejected
);
  import ewp_pkg::*;
  logic [9:0] busyCnt;
  logic [1:0] bp;
  logic inProt;
  assign bp = {statusView.blockProtectHi, statusView.blockProtectLo};
  assign inProt = (bp == 2'h3) || (bp == 2'h2 && memWr.addr >= PROT_HALF_BASE)
    || (bp == 2'h1 && memWr.addr >= PROT_QUARTER_BASE);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyCnt <= 10'h000;
    end else begin
      busyCnt <= statusView.writeBusy ? busyCnt + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence csIdle;
    pins.chipSelN [*8];
  endsequence
  sequence csSel;
    !pins.chipSelN [*8];
  endsequence
  a_reset_state: assert property (disable iff (1'b0)
    rst |=> !statusView.writeLatchFlag && standby && serialOutOeN)
    else $error("state during reset wrong");
  a_latch_set_cs: assert property (
    $rose(statusView.writeLatchFlag) |-> $past(pins.chipSelN))
    else $error("latch set while selected");
  a_busy_length: assert property (
    $fell(statusView.writeBusy) |-> busyCnt == 10'(WRITE_CYCLE_CYC))
    else $error("write cycle length wrong");
  a_latch_end_write: assert property (
    $fell(statusView.writeBusy) |-> $fell(statusView.writeLatchFlag))
    else $error("latch not cleared at write end");
  a_write_in_cycle: assert property (
    memWr.valid |-> statusView.writeBusy && statusView.writeLatchFlag)
    else $error("array write outside write cycle");
  a_no_prot_write: assert property (
    memWr.valid |-> !inProt)
    else $error("protected address written");
  a_status_guard: assert property (
    $changed({statusView.pinProtectEnable, bp}) |-> $past(statusView.writeLatchFlag)
    && !($past(statusView.pinProtectEnable) && !$past(pins.writeProtectN)))
    else $error("status changed while guarded");
  a_oe_idle: assert property (
    csIdle |-> serialOutOeN)
    else $error("output driven while deselected");
  a_standby_idle: assert property (
    csIdle ##0 !statusView.writeBusy |-> standby)
    else $error("standby low while idle");
  a_reject_pulse: assert property (
    writeRejected |=> !writeRejected && !statusView.writeBusy)
    else $error("reject pulse wrong");
  a_standby_sel: assert property (
    csSel |-> !standby)
    else $error("standby high while selected");
endmodule : ewp_ctrl_props

bind ewp_ctrl ewp_ctrl_props u_props (.clk(clk), .rst(rst), .pins(pins),
  .serialOut(serialOut), .serialOutOeN(serialOutOeN), .memRdAddr(memRdAddr),
  .memRdData(memRdData), .memWr(memWr), .statusView(statusView), .standby(standby),
  .writeRejected(writeRejected));
`default_nettype wire

// [sim/ewp_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========
// serial host, mode 0, msb first
module ewp_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output ewp_pkg::ewp_pins_t pins,
  input wire logic serialOut,
  input wire logic serialOutOeN
);
  import ewp_pkg::*;
  logic oeLow;
  initial begin
    pins = PIN_SYNC_RESET;
    oeLow = 1'b0;
  end
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : waitClk
  task automatic setWp(input logic level);
    pins.writeProtectN = level;
    waitClk(8);
  endtask : setWp
  // one framed transfer of n bits
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    oeLow = 1'b0;
    pins.chipSelN = 1'b0;
    waitClk(8);
    for (int i = n - 1; i >= 0; i--) begin
      pins.serialIn = tx[i];
      waitClk(8);
      pins.serialClk = 1'b1;
      // a released line reads as the inverse of its last level
      rx = {rx[62:0], serialOutOeN ? !serialOut : serialOut};
      oeLow = oeLow | !serialOutOeN;
      waitClk(8);
      pins.serialClk = 1'b0;
    end
    waitClk(8);
    pins.chipSelN = 1'b1;
    pins.serialIn = !pins.serialIn;
    waitClk(8);
  endtask : xfer
endmodule : ewp_host_model
`default_nettype wire

// [sim/test_eeprom_write_protect_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========
// bench top
module test_eeprom_write_protect_ctrl;
  import ewp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ewp_pins_t pins;
  logic serialOut;
  logic serialOutOeN;
  logic [ADDR_W-1:0] memRdAddr;
  logic [7:0] memRdData;
  ewp_mem_wr_t memWr;
  ewp_mem_wr_t lastWr;
  ewp_status_t statusView;
  logic standby;
  logic writeRejected;
  logic [63:0] rx;
  int errors = 0;
  int comparisons = 0;
  int wrCount = 0;
  int rejCount = 0;
  int cycles = 0;
  assign memRdData = memRdAddr[7:0] ^ 8'h5A;
  always #5 clk = ~clk;
  ewp_ctrl dut (.clk(clk), .rst(rst), .pins(pins), .serialOut(serialOut),
    .serialOutOeN(serialOutOeN), .memRdAddr(memRdAddr), .memRdData(memRdData),
    .memWr(memWr), .statusView(statusView), .standby(standby),
    .writeRejected(writeRejected));
  ewp_host_model host (.clk(clk), .pins(pins), .serialOut(serialOut),
    .serialOutOeN(serialOutOeN));
  always @(posedge clk) begin
    if (memWr.valid === 1'b1) begin
      wrCount++;
      lastWr = memWr;
    end
    if (writeRejected === 1'b1) rejCount++;
    cycles++;
    if (cycles == 40000) begin
      errors++;
      summarize();
    end
  end
  // ==========
  // shared tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  task automatic waitIdle();
    int k;
    k = 0;
    while (statusView.writeBusy === 1'b1 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    host.waitClk(2);
  endtask : waitIdle
  task automatic arrWr(input logic [14:0] a, input logic setL, input logic ok);
    int w0;
    int r0;
    w0 = wrCount;
    r0 = rejCount;
    if (setL) host.xfer(CMD_SET_LATCH, 8, rx);
    host.xfer({CMD_WRITE, 1'b0, a, 8'h3C}, 32, rx);
    waitIdle();
    check("array writes", ok, wrCount - w0);
    check("rejects", !ok, rejCount - r0);
    if (ok) check("write addr", {1'b0, a}, {1'b0, lastWr.addr});
    host.xfer(CMD_CLEAR_LATCH, 8, rx);
  endtask : arrWr
  task automatic stWr(input logic [7:0] v, input logic ok);
    logic [7:0] old;
    old = statusView & 8'h8C;
    host.xfer(CMD_SET_LATCH, 8, rx);
    host.xfer({CMD_WRITE_STATUS, v}, 16, rx);
    waitIdle();
    check("status bits", ok ? v & 8'h8C : old, statusView & 8'h8C);
    check("latch after", !ok, statusView.writeLatchFlag);
    host.xfer(CMD_CLEAR_LATCH, 8, rx);
  endtask : stWr
  // ==========
  // scenarios
  task automatic tPowerOn();
    check("status", 16'h0000, statusView);
    check("standby", 16'h0001, standby);
    check("oe", 16'h0001, serialOutOeN);
    host.xfer({CMD_READ_STATUS, 8'h00}, 16, rx);
    check("status read", 16'h0000, rx[7:0]);
    host.xfer({CMD_READ, 16'h0123, 8'h00}, 32, rx);
    check("array read", 8'h23 ^ 8'h5A, rx[7:0]);
  endtask : tPowerOn
  task automatic tLatch();
    host.xfer({CMD_SET_LATCH, 1'b0}, 9, rx);
    check("latch odd frame", 16'h0000, statusView.writeLatchFlag);
    host.xfer(CMD_SET_LATCH, 8, rx);
    check("latch set", 16'h0001, statusView.writeLatchFlag);
    host.xfer(CMD_CLEAR_LATCH, 8, rx);
    check("latch clear", 16'h0000, statusView.writeLatchFlag);
    arrWr(15'h0010, 1'b0, 1'b0);
  endtask : tLatch
  task automatic tArray();
    int w0;
    w0 = wrCount;
    host.xfer(CMD_SET_LATCH, 8, rx);
    host.xfer({CMD_WRITE, 16'h0020, 7'h2A}, 31, rx);
    check("short frame", 16'h0000, statusView.writeBusy);
    host.xfer({CMD_WRITE, 16'h003F, 8'hA1, 8'hB2}, 40, rx);
    host.xfer({CMD_READ_STATUS, 8'h00}, 16, rx);
    check("busy read", 16'h0001, rx[0]);
    host.xfer({CMD_READ, 16'h0123, 8'h00}, 32, rx);
    check("read ignored", 16'h0000, host.oeLow);
    waitIdle();
    check("page writes", 16'h0002, wrCount - w0);
    check("wrap addr", 16'h0000, {1'b0, lastWr.addr});
    check("wrap data", 16'h00B2, lastWr.data);
    check("latch done", 16'h0000, statusView.writeLatchFlag);
  endtask : tArray
  task automatic tGuard();
    host.setWp(1'b0);
    stWr(8'h80, 1'b1);
    stWr(8'h8C, 1'b0);
    host.setWp(1'b1);
    stWr(8'h8C, 1'b1);
  endtask : tGuard
  task automatic tProtect();
    logic [14:0] addrs [3];
    logic ok;
    addrs = '{15'h2000, 15'h5000, 15'h7000};
    for (int b = 0; b < 4; b++) begin
      stWr({4'h0, 2'(b), 2'h0}, 1'b1);
      for (int i = 0; i < 3; i++) begin
        ok = !(b == 3 || (b == 2 && addrs[i] >= PROT_HALF_BASE)
          || (b == 1 && addrs[i] >= PROT_QUARTER_BASE));
        arrWr(addrs[i], 1'b1, ok);
      end
    end
  endtask : tProtect
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    host.waitClk(8);
    tPowerOn();
    tLatch();
    tArray();
    tGuard();
    tProtect();
    summarize();
  end
endmodule : test_eeprom_write_protect_ctrl
`default_nettype wire
